// >>> smc_regs.svh
/*
  Register offsets, field positions, reset values and counts of the serial
  port block. Assumes an Avalon-MM slave with 32-bit data and byte
  addresses.
*/
// Overview of operation
// - Master with clock pin disable set releases the serial clock pin.
// - Data output pin disable set releases the data output pin.
// - Word width select set gives 16-bit words, clear gives 8-bit words.
// - Master samples input at end of output time if set, else middle.
// - Unframed, edge select set: output changes active-to-idle, else idle-to-active.
// - Slave uses the slave select pin only with slave select enable set.
// - Clock idle polarity set idles the clock high, clear idles it low.
// - Master enable set makes the port link master, clear makes it slave.
// - Secondary divider divides by eight minus its value.
// - Primary divider gives 1, 4, 16 or 64 for 11, 10, 01, 00.
// - Serial clock rate is the clock over the product of both prescale ratios rounded down to even, at least 2.
// - Framed enable set turns framed operation on.
// - Frame sync direction set takes sync as input, clear drives it.
// - Frame sync polarity set makes the pulse active high, else low.
// - Frame sync edge set coincides with first bit clock, else precedes.
// - Enhanced buffer enable set uses multi-entry buffers, else one.
// - Unimplemented control bits always read as zero.
// - A master not waiting on an input frame sync starts as soon as the buffer is written.
// - A word arriving with the receive buffer full sets the overflow.
// - Port enable gives the port its pins, clear disables it.
`ifndef SMC_REGS_SVH
`define SMC_REGS_SVH

`define SMC_ADDR_CON1 5'h00
`define SMC_ADDR_CON2 5'h04
`define SMC_ADDR_STAT 5'h08
`define SMC_ADDR_BUF 5'h0C

`define SMC_CON1_MASK 16'h1FFF
`define SMC_CON2_MASK 16'hE003
`define SMC_CON1_RESET 16'h0000
`define SMC_CON2_RESET 16'h0000

`define SMC_CLOCK_PIN_DISABLE 12
`define SMC_DATA_OUT_PIN_DISABLE 11
`define SMC_WORD_WIDTH_SELECT 10
`define SMC_INPUT_SAMPLE_PHASE 9
`define SMC_CLOCK_EDGE_SELECT 8
`define SMC_SLAVE_SELECT_ENABLE 7
`define SMC_CLOCK_IDLE_POLARITY 6
`define SMC_MASTER_ENABLE 5
`define SMC_SECONDARY_DIVIDER 4:2
`define SMC_PRIMARY_DIVIDER 1:0
`define SMC_FRAMED_ENABLE 15
`define SMC_FRAME_SYNC_DIRECTION 14
`define SMC_FRAME_SYNC_POLARITY 13
`define SMC_FRAME_SYNC_EDGE 1
`define SMC_ENHANCED_BUFFER_ENABLE 0
`define SMC_PORT_ENABLE 15
`define SMC_SHIFT_EMPTY 7
`define SMC_RECEIVE_OVERFLOW_FLAG 6
`define SMC_TX_FULL 1
`define SMC_RX_FULL 0

`define SMC_WORD_BITS 5'h10
`define SMC_BYTE_BITS 5'h08
`define SMC_DEPTH_ENH 3'h4
`define SMC_DEPTH_LEG 3'h1
`define SMC_PRI_11 7'h01
`define SMC_PRI_10 7'h04
`define SMC_PRI_01 7'h10
`define SMC_PRI_00 7'h40
`define SMC_SEC_BASE 4'h8

`endif

// >>> smc_pkg.sv
/*
  Types of the serial port block. Assumes nothing of its surroundings.
*/
package smc_pkg;
  typedef enum logic [1:0] {
    st_idle = 2'h0,
    st_fsync = 2'h1,
    st_shift = 2'h3,
    st_done = 2'h2
  } smc_state_e;
endpackage : smc_pkg

// >>> smc_clk_if.sv
/*
  Carrier between the port and its prescaler. Assumes one clock.
*/
`timescale 1ns/10ps
`default_nettype none
interface smc_clk_if;
  logic [1:0] primary;
  logic [2:0] secondary;
  logic tick;
  modport gen (input primary, input secondary, output tick);
  modport user (output primary, output secondary, input tick);
endinterface : smc_clk_if
`default_nettype wire

// >>> smc_prescaler.sv
/*
  Two-stage prescaler giving a one-cycle tick at each half serial clock
  period. Assumes the dividers are steady while a word is shifted.
*/
`timescale 1ns/10ps
`default_nettype none
`include "smc_regs.svh"
module smc_prescaler (
  // Clock and reset.
  input wire logic i_mclk,
  input wire logic i_reset_n,
  // Divider settings and tick.
  smc_clk_if.gen clk_if
);
  logic [6:0] pri;
  logic [3:0] sec;
  logic [10:0] ratio;
  logic [9:0] half;
  logic [9:0] cnt_q;

  always_comb begin
    case (clk_if.primary)
      2'h3: pri = `SMC_PRI_11;
      2'h2: pri = `SMC_PRI_10;
      2'h1: pri = `SMC_PRI_01;
      default: pri = `SMC_PRI_00;
    endcase
    sec = `SMC_SEC_BASE - {1'b0, clk_if.secondary};
    ratio = pri * sec;
    half = ratio[10:1];
    if (half == 10'h000) begin
      half = 10'h001;
    end
  end

  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cnt_q <= 10'h000;
      clk_if.tick <= 1'b0;
    end else if (cnt_q >= half - 10'h001) begin
      cnt_q <= 10'h000;
      clk_if.tick <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 10'h001;
      clk_if.tick <= 1'b0;
    end
  end

  tick_spacing_a: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    clk_if.tick && half > 10'h001 |=> !clk_if.tick)
    else $error("Prescaler ticks closer than the half period.");
endmodule : smc_prescaler
`default_nettype wire

// >>> smc_top.sv
/*
  Serial port with master and slave operation, framing and selectable
  buffering, programmed over an Avalon-MM slave. Assumes pin inputs are
  synchronous to i_mclk and that the pads resolve the enables.
*/
`timescale 1ns/10ps
`default_nettype none
`include "smc_regs.svh"
module smc_top (
  // Clock and reset.
  input wire logic i_mclk,
  input wire logic i_reset_n,
  // Avalon-MM register slave.
  input wire logic [4:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [3:0] i_avs_byteenable,
  input wire logic [31:0] i_avs_writedata,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  // Serial clock pin.
  input wire logic i_serial_clock_pin,
  output logic o_serial_clock_pin,
  output logic o_serial_clock_pin_oe,
  // Serial data pins.
  input wire logic i_serial_data_in_pin,
  output logic o_serial_data_out_pin,
  output logic o_serial_data_out_pin_oe,
  // Slave select and frame sync pin.
  input wire logic i_slave_select_pin,
  output logic o_slave_select_pin,
  output logic o_slave_select_pin_oe
);
  logic req, acc, wait_q;
  logic [31:0] rdata_q;
  logic [15:0] con1_q, con2_q, stat, rd_mux, wmask;
  logic port_en_q, ovf_q;
  logic [15:0] tx_mem [4];
  logic [15:0] rx_mem [4];
  logic [1:0] tx_wp_q, tx_rp_q, rx_wp_q, rx_rp_q;
  logic [2:0] tx_cnt_q, rx_cnt_q, depth;
  smc_pkg::smc_state_e st_q, st_d;
  logic [5:0] k_q;
  logic [4:0] bits_q, width;
  logic [15:0] tx_sh_q, rx_sh_q, ld_word, rx_word;
  logic sck_q, sck_prev_q, fs_q, sck_oe_q, sdo_oe_q, fs_oe_q;
  logic master, clock_idle_polarity, cke_eff, smp_eff, framed, fsd, fpol, fedge;
  logic selected, fs_in_on, start_ok, fs_on;
  logic ev, lead, chg, first_chg, smp_edge, in_win, done;
  logic wr_buf, rd_buf, tx_push, tx_pop, rx_push, rx_pop, ovf_set;

  smc_clk_if clk_if ();

  smc_prescaler u_prescaler (
    .i_mclk(i_mclk),
    .i_reset_n(i_reset_n),
    .clk_if(clk_if)
  );

  // Field decode.
  assign master = con1_q[`SMC_MASTER_ENABLE];
  assign clock_idle_polarity = con1_q[`SMC_CLOCK_IDLE_POLARITY];
  assign framed = con2_q[`SMC_FRAMED_ENABLE];
  assign fsd = con2_q[`SMC_FRAME_SYNC_DIRECTION];
  assign fpol = con2_q[`SMC_FRAME_SYNC_POLARITY];
  assign fedge = con2_q[`SMC_FRAME_SYNC_EDGE];
  assign cke_eff = con1_q[`SMC_CLOCK_EDGE_SELECT] & ~framed;
  assign smp_eff = con1_q[`SMC_INPUT_SAMPLE_PHASE] & master;
  assign width = con1_q[`SMC_WORD_WIDTH_SELECT] ? `SMC_WORD_BITS
                                                : `SMC_BYTE_BITS;
  assign depth = con2_q[`SMC_ENHANCED_BUFFER_ENABLE] ? `SMC_DEPTH_ENH
                                                     : `SMC_DEPTH_LEG;
  assign clk_if.primary = con1_q[`SMC_PRIMARY_DIVIDER];
  assign clk_if.secondary = con1_q[`SMC_SECONDARY_DIVIDER];

  // Bus slave: one wait cycle, then the access takes effect.
  assign req = i_avs_read | i_avs_write;
  assign acc = req & ~wait_q;
  assign wmask = {{8{i_avs_byteenable[1]}}, {8{i_avs_byteenable[0]}}};
  assign wr_buf = acc & i_avs_write & (i_avs_address == `SMC_ADDR_BUF);
  assign rd_buf = acc & i_avs_read & (i_avs_address == `SMC_ADDR_BUF);

  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      wait_q <= 1'b1;
    end else begin
      wait_q <= ~(req & wait_q);
    end
  end

  always_comb begin
    stat = 16'h0000;
    stat[`SMC_PORT_ENABLE] = port_en_q;
    stat[`SMC_SHIFT_EMPTY] = (st_q == smc_pkg::st_idle);
    stat[`SMC_RECEIVE_OVERFLOW_FLAG] = ovf_q;
    stat[`SMC_TX_FULL] = (tx_cnt_q == depth);
    stat[`SMC_RX_FULL] = (rx_cnt_q == depth);
    case (i_avs_address)
      `SMC_ADDR_CON1: rd_mux = con1_q & `SMC_CON1_MASK;
      `SMC_ADDR_CON2: rd_mux = con2_q & `SMC_CON2_MASK;
      `SMC_ADDR_STAT: rd_mux = stat;
      `SMC_ADDR_BUF: rd_mux = rx_mem[rx_rp_q];
      default: rd_mux = 16'h0000;
    endcase
  end

  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rdata_q <= 32'h00000000;
    end else if (req & wait_q) begin
      rdata_q <= {16'h0000, rd_mux};
    end
  end

  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      con1_q <= `SMC_CON1_RESET;
      con2_q <= `SMC_CON2_RESET;
      port_en_q <= 1'b0;
    end else if (acc & i_avs_write) begin
      if (i_avs_address == `SMC_ADDR_CON1) begin
        con1_q <= ((con1_q & ~wmask) | (i_avs_writedata[15:0] & wmask))
                  & `SMC_CON1_MASK;
      end
      if (i_avs_address == `SMC_ADDR_CON2) begin
        con2_q <= ((con2_q & ~wmask) | (i_avs_writedata[15:0] & wmask))
                  & `SMC_CON2_MASK;
      end
      if (i_avs_address == `SMC_ADDR_STAT && i_avs_byteenable[1]) begin
        port_en_q <= i_avs_writedata[`SMC_PORT_ENABLE];
      end
    end
  end

  // Overflow: a new overflow wins over a clear in the same cycle.
  assign ovf_set = (st_q == smc_pkg::st_done) & (rx_cnt_q == depth);
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      ovf_q <= 1'b0;
    end else if (ovf_set) begin
      ovf_q <= 1'b1;
    end else if (acc && i_avs_write && i_avs_address == `SMC_ADDR_STAT
                 && i_avs_byteenable[0]
                 && !i_avs_writedata[`SMC_RECEIVE_OVERFLOW_FLAG]) begin
      ovf_q <= 1'b0;
    end
  end

  // Transmit buffer.
  assign tx_push = wr_buf & port_en_q & (tx_cnt_q < depth);
  assign tx_pop = (st_q == smc_pkg::st_idle) & start_ok & (tx_cnt_q != 3'h0);
  assign ld_word = tx_pop ? tx_mem[tx_rp_q] : 16'h0000;
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      tx_wp_q <= 2'h0;
      tx_rp_q <= 2'h0;
      tx_cnt_q <= 3'h0;
    end else begin
      if (tx_push) begin
        tx_wp_q <= tx_wp_q + 2'h1;
      end
      if (tx_pop) begin
        tx_rp_q <= tx_rp_q + 2'h1;
      end
      tx_cnt_q <= tx_cnt_q + {2'h0, tx_push} - {2'h0, tx_pop};
    end
  end
  always_ff @(posedge i_mclk) begin
    if (tx_push) begin
      tx_mem[tx_wp_q] <= i_avs_writedata[15:0];
    end
  end

  // Receive buffer; a full buffer discards the new word.
  assign rx_push = (st_q == smc_pkg::st_done) & (rx_cnt_q < depth);
  assign rx_pop = rd_buf & (rx_cnt_q != 3'h0);
  assign rx_word = (width == `SMC_WORD_BITS) ? rx_sh_q : {8'h00, rx_sh_q[7:0]};
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rx_wp_q <= 2'h0;
      rx_rp_q <= 2'h0;
      rx_cnt_q <= 3'h0;
    end else begin
      if (rx_push) begin
        rx_wp_q <= rx_wp_q + 2'h1;
      end
      if (rx_pop) begin
        rx_rp_q <= rx_rp_q + 2'h1;
      end
      rx_cnt_q <= rx_cnt_q + {2'h0, rx_push} - {2'h0, rx_pop};
    end
  end
  always_ff @(posedge i_mclk) begin
    if (rx_push) begin
      rx_mem[rx_wp_q] <= rx_word;
    end
  end

  // Edge events from the prescaler or from the external clock.
  assign selected = master | framed | ~con1_q[`SMC_SLAVE_SELECT_ENABLE]
                    | ~i_slave_select_pin;
  assign fs_in_on = (i_slave_select_pin == fpol);
  assign ev = master ? clk_if.tick
                     : (i_serial_clock_pin != sck_prev_q) & selected;
  assign lead = master ? ~k_q[0] : (sck_prev_q == clock_idle_polarity);
  assign chg = lead ^ cke_eff;
  assign first_chg = chg & ~cke_eff & (k_q == 6'h00);
  assign smp_edge = smp_eff ? (chg & ~first_chg) : ~chg;
  assign in_win = k_q < {width, 1'b0};
  assign done = (bits_q == width) & ~in_win;
  assign start_ok = port_en_q & selected & (~framed | ~fsd | fs_in_on)
                    & (~master | tx_cnt_q != 3'h0);

  always_comb begin
    st_d = st_q;
    case (st_q)
      smc_pkg::st_idle: begin
        if (start_ok) begin
          st_d = (framed & ~fsd & ~fedge) ? smc_pkg::st_fsync
                                          : smc_pkg::st_shift;
        end
      end
      smc_pkg::st_fsync: begin
        if (ev && k_q[0]) begin
          st_d = smc_pkg::st_shift;
        end
      end
      smc_pkg::st_shift: begin
        if (!selected) begin
          st_d = smc_pkg::st_idle;
        end else if (done) begin
          st_d = smc_pkg::st_done;
        end
      end
      smc_pkg::st_done: st_d = smc_pkg::st_idle;
      default: st_d = smc_pkg::st_idle;
    endcase
    if (!port_en_q) begin
      st_d = smc_pkg::st_idle;
    end
  end

  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      st_q <= smc_pkg::st_idle;
    end else begin
      st_q <= st_d;
    end
  end

  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      k_q <= 6'h00;
    end else if (st_q == smc_pkg::st_fsync && ev) begin
      k_q <= k_q[0] ? 6'h00 : 6'h01;
    end else if (st_q == smc_pkg::st_shift && ev) begin
      k_q <= k_q + 6'h01;
    end else if (st_q != smc_pkg::st_shift && st_q != smc_pkg::st_fsync) begin
      k_q <= 6'h00;
    end
  end

  // Shift registers, most significant bit first.
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      tx_sh_q <= 16'h0000;
      rx_sh_q <= 16'h0000;
      bits_q <= 5'h00;
    end else if (st_q == smc_pkg::st_idle) begin
      bits_q <= 5'h00;
      if (start_ok) begin
        tx_sh_q <= (width == `SMC_WORD_BITS) ? ld_word
                                             : {ld_word[7:0], 8'h00};
      end
    end else if (st_q == smc_pkg::st_shift && ev) begin
      if (chg && !first_chg && in_win) begin
        tx_sh_q <= {tx_sh_q[14:0], 1'b0};
      end
      if (smp_edge && bits_q != width) begin
        rx_sh_q <= {rx_sh_q[14:0], i_serial_data_in_pin};
        bits_q <= bits_q + 5'h01;
      end
    end
  end

  // Pin drivers.
  assign fs_on = framed & ~fsd & ((st_q == smc_pkg::st_fsync)
                 | (st_q == smc_pkg::st_shift & fedge & k_q < 6'h02));
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      sck_prev_q <= 1'b0;
      sck_q <= 1'b0;
      fs_q <= 1'b0;
      sck_oe_q <= 1'b0;
      sdo_oe_q <= 1'b0;
      fs_oe_q <= 1'b0;
    end else begin
      sck_prev_q <= i_serial_clock_pin;
      if (!master || st_q != smc_pkg::st_shift) begin
        sck_q <= clock_idle_polarity;
      end else if (ev && in_win) begin
        sck_q <= ~sck_q;
      end
      fs_q <= fs_on ? fpol : ~fpol;
      sck_oe_q <= port_en_q & master
                  & ~con1_q[`SMC_CLOCK_PIN_DISABLE];
      sdo_oe_q <= port_en_q & ~con1_q[`SMC_DATA_OUT_PIN_DISABLE]
                  & selected;
      fs_oe_q <= port_en_q & framed & ~fsd;
    end
  end

  assign o_avs_readdata = rdata_q;
  assign o_avs_waitrequest = wait_q;
  assign o_serial_clock_pin = sck_q;
  assign o_serial_clock_pin_oe = sck_oe_q;
  assign o_serial_data_out_pin = tx_sh_q[15];
  assign o_serial_data_out_pin_oe = sdo_oe_q;
  assign o_slave_select_pin = fs_q;
  assign o_slave_select_pin_oe = fs_oe_q;

  sck_pin_off_a: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    o_serial_clock_pin_oe |-> $past(master && !con1_q[12] && port_en_q))
    else $error("Clock pin driven while disabled or in slave operation.");
  sdo_pin_off_a: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    $past(con1_q[`SMC_DATA_OUT_PIN_DISABLE]) |-> !o_serial_data_out_pin_oe)
    else $error("Data output pin driven while disabled.");
  word_bits_a: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    st_q == smc_pkg::st_done |-> $past(bits_q) == $past(width))
    else $error("Word finished with the wrong bit count.");
  sck_idle_a: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    $past(st_q == smc_pkg::st_idle, 2) && $past(st_q == smc_pkg::st_idle)
    |-> o_serial_clock_pin == $past(clock_idle_polarity))
    else $error("Clock not at its idle level between words.");
  master_start_a: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    tx_push && master && port_en_q && st_q == smc_pkg::st_idle && !framed
    |-> ##[1:2] st_q == smc_pkg::st_shift)
    else $error("Master did not start after a buffer write.");
  rx_overflow_a: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    st_q == smc_pkg::st_done && rx_cnt_q == depth && !rx_pop
    |=> ovf_q && rx_cnt_q == $past(rx_cnt_q))
    else $error("Overflow word not discarded or flag not set.");
  reserved_zero_a: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    !o_avs_waitrequest && i_avs_read && i_avs_address == `SMC_ADDR_CON2
    |-> o_avs_readdata[12:2] == 11'h000 && o_avs_readdata[31:16] == 16'h0000)
    else $error("Unimplemented control bits read as one.");
  bus_answer_a: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    req && o_avs_waitrequest |=> !o_avs_waitrequest)
    else $error("Bus request not answered in one wait cycle.");
  fsync_drive_a: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    o_slave_select_pin_oe |-> $past(framed && !fsd && port_en_q))
    else $error("Frame sync driven while configured as input.");
  disabled_idle_a: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    !port_en_q |=> st_q == smc_pkg::st_idle)
    else $error("Engine active while the port is disabled.");
endmodule : smc_top
`default_nettype wire

// >>> smc_peer.sv
/*
  Model of an external serial slave on the far side of the port. Assumes
  the bench sets polarity and edge select and holds i_sel over a word.
*/
`timescale 1ns/10ps
`default_nettype none
module smc_peer (
  // Clock and link.
  input wire logic i_mclk,
  input wire logic i_sck,
  input wire logic i_sdo,
  output logic o_sdi,
  // Settings and data from the bench.
  input wire logic i_ckp,
  input wire logic i_cke,
  input wire logic i_sel,
  input wire logic [15:0] i_word,
  output logic [15:0] o_got
);
  logic [15:0] sr_q = 16'h0000;
  logic psck_q = 1'b0;
  logic psel_q = 1'b0;
  logic first_q = 1'b0;
  logic last_q = 1'b0;
  logic lead;
  logic trail;
  assign lead = (i_sck != psck_q) && (i_sck != i_ckp);
  assign trail = (i_sck != psck_q) && (i_sck == i_ckp);
  // A released line shows the inverse of its last bit.
  assign o_sdi = i_sel ? sr_q[15] : ~last_q;
  always @(posedge i_mclk) begin
    psck_q <= i_sck;
    psel_q <= i_sel;
    if (i_sel) begin
      last_q <= sr_q[15];
    end
    if (i_sel && !psel_q) begin
      sr_q <= i_word;
      first_q <= 1'b1;
    end else if (i_sel) begin
      if (i_cke ? trail : (lead && !first_q)) begin
        sr_q <= sr_q << 1;
      end
      if (i_cke ? lead : trail) begin
        o_got <= {o_got[14:0], i_sdo};
      end
      if (lead) begin
        first_q <= 1'b0;
      end
    end
  end
endmodule : smc_peer
`default_nettype wire

// >>> tb_top.sv
/*
  Self-checking bench of the serial port: registers, master transfers over
  divider and clock settings, framing and overflow. Assumes smc_peer.
*/
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic clk = 1'b0;
  logic rst_n, rd, wr, sel, ckp_r, cke_r, ss_in, fs_act;
  logic wq, sck_o, sck_oe, sdo_o, sdo_oe, fs_o, fs_oe, sdi;
  logic s_oe, d_oe, fs_seen, psck;
  logic [4:0] adr;
  logic [31:0] wd, rdat;
  logic [15:0] pword, pgot;
  wire sck_w = sck_oe ? sck_o : ckp_r;
  wire sdo_w = sdo_oe ? sdo_o : 1'b1;
  wire ss_w = fs_oe ? fs_o : ss_in;
  int n_mismatch = 0;
  int checked = 0;
  int cyc = 0;
  int cnt = 0;
  int last_iv = 0;
  logic [1:0] pri_t [5] = '{2'h3, 2'h2, 2'h3, 2'h1, 2'h0};
  logic [2:0] sec_t [5] = '{3'h4, 3'h6, 3'h0, 3'h7, 3'h7};
  always #5 clk = ~clk;
  smc_top i_smc_top (.i_mclk(clk), .i_reset_n(rst_n), .i_avs_address(adr),
    .i_avs_read(rd), .i_avs_write(wr), .i_avs_byteenable(4'hF),
    .i_avs_writedata(wd), .o_avs_readdata(rdat), .o_avs_waitrequest(wq),
    .i_serial_clock_pin(sck_w), .o_serial_clock_pin(sck_o),
    .o_serial_clock_pin_oe(sck_oe), .i_serial_data_in_pin(sdi),
    .o_serial_data_out_pin(sdo_o), .o_serial_data_out_pin_oe(sdo_oe),
    .i_slave_select_pin(ss_w), .o_slave_select_pin(fs_o),
    .o_slave_select_pin_oe(fs_oe));
  smc_peer i_smc_peer (.i_mclk(clk), .i_sck(sck_w), .i_sdo(sdo_w),
    .o_sdi(sdi), .i_ckp(ckp_r), .i_cke(cke_r), .i_sel(sel),
    .i_word(pword), .o_got(pgot));
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    for (int k = 0; k < 16; k++) v = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    return v;
  endfunction : lfsr
  function automatic int hp(input logic [1:0] p, input logic [2:0] s);
    int m;
    m = (1 << (2 * (3 - int'(p)))) * (8 - int'(s));
    return (m < 2) ? 1 : m / 2;
  endfunction : hp
  task summarize();
    $display("checked %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : summarize
  task chk(input logic [31:0] g, input logic [31:0] e, input string m);
    checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("ERROR %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask : chk
  task av(input logic w, input logic [4:0] a, input logic [15:0] d,
          output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk);
    rd <= ~w;
    wr <= w;
    adr <= a;
    wd <= {16'h0000, d};
    do begin
      @(posedge clk);
      n++;
    end while (wq !== 1'b0 && n < 100);
    chk(wq, 1'b0, "wait");
    q = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask : av
  task run(input logic [15:0] tx, input logic [15:0] px,
           output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk);
    pword = px;
    sel <= 1'b1;
    av(1'b1, 5'h0C, tx, q);
    av(1'b0, 5'h08, 16'h0000, q);
    chk(q[7], 1'b0, "start");
    do begin
      av(1'b0, 5'h08, 16'h0000, q);
      n++;
    end while (q[7] !== 1'b1 && n < 2000);
    chk(q[7], 1'b1, "end");
    sel <= 1'b0;
  endtask : run
  always @(posedge clk) begin
    cyc++;
    cnt++;
    if (sck_o !== psck) begin
      last_iv = cnt;
      cnt = 0;
    end
    psck = sck_o;
    if (sck_oe === 1'b1) s_oe = 1'b1;
    if (sdo_oe === 1'b1) d_oe = 1'b1;
    if (fs_oe === 1'b1 && fs_o === fs_act) fs_seen = 1'b1;
    if (cyc == 80000) begin
      n_mismatch++;
      summarize();
    end
  end
  initial begin
    logic [31:0] q, r;
    logic [15:0] c1, c2, tx, px, m;
    logic w16, dsck, dsdo;
    int hx;
    r = 32'h7034AE1E;
    rst_n = 1'b0;
    {rd, wr, sel, ckp_r, cke_r, fs_act} = 6'h00;
    adr = 5'h00;
    wd = 32'h00000000;
    pword = 16'h0000;
    ss_in = 1'b1;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 2; i++) begin
      av(1'b0, 5'(4 * i), 16'h0000, q);
      chk(q, 32'h00000000, "reset value");
      r = lfsr(r);
      av(1'b1, 5'(4 * i), r[15:0], q);
      av(1'b0, 5'(4 * i), 16'h0000, q);
      m = i ? 16'hE003 : 16'h1FFF;
      chk(q, {16'h0000, r[15:0] & m}, "mask");
    end
    av(1'b1, 5'h10, 16'hFFFF, q);
    av(1'b0, 5'h10, 16'h0000, q);
    chk(q, 32'h00000000, "unmapped");
    for (int i = 0; i < 10; i++) begin
      r = lfsr(r);
      w16 = r[3];
      dsdo = (i == 8);
      dsck = (i == 9);
      c2 = (i == 6 || i == 7) ? {2'h2, r[4], 11'h000, r[5], 1'b0} : 16'h0000;
      cke_r = r[0] & ~c2[15];
      ckp_r = r[1];
      fs_act = c2[13];
      c1 = {3'h0, dsck, dsdo, w16, r[2], cke_r, 1'b0, ckp_r, 1'b1,
            sec_t[i % 5], pri_t[i % 5]};
      av(1'b1, 5'h00, c1, q);
      av(1'b1, 5'h04, c2, q);
      av(1'b1, 5'h08, 16'h8000, q);
      if (!dsck) chk(sck_o, ckp_r, "idle level");
      {s_oe, d_oe, fs_seen} = 3'h0;
      r = lfsr(r);
      tx = r[15:0];
      px = r[31:16];
      run(tx, w16 ? px : {px[7:0], 8'h00}, q);
      av(1'b0, 5'h0C, 16'h0000, q);
      m = w16 ? 16'hFFFF : 16'h00FF;
      if (!dsck) chk(q, 32'(px & m), "rx");
      if (!dsck && !dsdo) chk(pgot & m, tx & m, "tx");
      hx = hp(c1[1:0], c1[4:2]);
      if (!dsck) chk(last_iv, hx, "half");
      chk(s_oe, !dsck, "clock drive");
      chk(d_oe, !dsdo, "data drive");
      if (c2[15]) chk(fs_seen, 1'b1, "fs");
      $display("transfer test %0d done", i);
    end
    {cke_r, ckp_r} = 2'h0;
    for (int e = 0; e < 2; e++) begin
      av(1'b1, 5'h00, 16'h0033, q);
      av(1'b1, 5'h04, 16'(e), q);
      av(1'b1, 5'h08, 16'h8000, q);
      r = lfsr(r);
      run(r[15:0], {r[23:16], 8'h00}, q);
      run(r[31:16], {~r[23:16], 8'h00}, q);
      av(1'b0, 5'h08, 16'h0000, q);
      chk(q[6], e == 0, "overflow");
      av(1'b0, 5'h0C, 16'h0000, q);
      chk(q, {24'h000000, r[23:16]}, "first kept");
      av(1'b0, 5'h0C, 16'h0000, q);
      $display("overflow test %0d done", e);
    end
    summarize();
  end
endmodule : tb_top
`default_nettype wire
